/* rtl/frs_host.sv */
// Host sequencer driving reset and select gating of a parallel flash
`timescale 1ns/100ps
`default_nettype none
`include "frs_map.svh"

module frs_host #(
  parameter int SETUP_CYC = `FRS_SETUP_CYC
) (
  input wire logic I_SYS_CLK,          // 50 MHz system clock
  input wire logic I_RST_N,            // Asynchronous reset, active low
  input wire logic I_PWR_GOOD,         // Supplies at operating minimum
  input wire logic I_WARM_RESET_REQ,   // Pulse: request a warm reset
  input wire logic I_USER_CE_N,        // User chip enable, active low
  input wire logic I_USER_OE_N,        // User output enable, active low
  input wire logic I_READY_BUSY_OUT_N, // Device ready/busy, low is busy
  output logic O_FLASH_RESET_N,        // Flash reset pin, active low
  output logic O_FLASH_CE_N,           // Flash chip enable, active low
  output logic O_FLASH_OE_N,           // Flash output enable, active low
  output logic O_ACCESS_READY          // Accesses are being passed on
);

  localparam logic [`FRS_CNT_W-1:0] SETUP_LOAD = `FRS_CNT_W'(SETUP_CYC);
  localparam logic [`FRS_CNT_W-1:0] RPH_LOAD = `FRS_CNT_W'(`FRS_RPH_CYC);
  localparam logic [`FRS_CNT_W-1:0] RH_LOAD = `FRS_CNT_W'(`FRS_RH_CYC);
  localparam logic [`FRS_CNT_W-1:0] RP_LOAD = `FRS_CNT_W'(`FRS_RP_CYC);
  localparam logic [`FRS_CNT_W-1:0] CNT_ONE = `FRS_CNT_W'(1);
  localparam logic [`FRS_CNT_W-1:0] CNT_MAX = {`FRS_CNT_W{1'b1}};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  frs_pkg::frs_state_type state_reg, state_next;
  logic [`FRS_CNT_W-1:0] cnt_reg, cnt_next;
  logic reset_n_reg, reset_n_next;
  logic ce_n_reg, ce_n_next;
  logic oe_n_reg, oe_n_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    reset_n_next = reset_n_reg;
    ce_n_next = 1'b1;
    oe_n_next = 1'b1;
    if (!I_PWR_GOOD) begin
      state_next = frs_pkg::FRS_PWR_OFF;
      reset_n_next = 1'b0;
      cnt_next = '0;
    end else begin
      unique case (state_reg)
        frs_pkg::FRS_PWR_OFF: begin
          state_next = frs_pkg::FRS_SUPPLY_SETUP;
          reset_n_next = 1'b0;
          cnt_next = SETUP_LOAD;
        end
        frs_pkg::FRS_SUPPLY_SETUP: begin
          if (cnt_reg > CNT_ONE) begin
            cnt_next = cnt_reg - CNT_ONE;
          end else begin
            // warm interval starts at setup end
            state_next = frs_pkg::FRS_RESET_LOW;
            cnt_next = RPH_LOAD;
          end
        end
        frs_pkg::FRS_RESET_LOW: begin
          // reset low for the warm interval
          reset_n_next = 1'b0;
          if (cnt_reg > CNT_ONE) begin
            cnt_next = cnt_reg - CNT_ONE;
          end else begin
            state_next = frs_pkg::FRS_RESET_HIGH;
            reset_n_next = 1'b1;
            cnt_next = RH_LOAD;
          end
        end
        frs_pkg::FRS_RESET_HIGH: begin
          if (cnt_reg > CNT_ONE) begin
            cnt_next = cnt_reg - CNT_ONE;
          end else begin
            state_next = frs_pkg::FRS_WAIT_READY;
          end
        end
        frs_pkg::FRS_WAIT_READY: begin
          // Device may still run a full cold reset
          // select gated until sequence ends
          if (I_READY_BUSY_OUT_N) begin
            state_next = frs_pkg::FRS_ACTIVE;
          end
        end
        frs_pkg::FRS_ACTIVE: begin
          if (I_WARM_RESET_REQ) begin
            // one pulse length covers the warm interval
            state_next = frs_pkg::FRS_RESET_LOW;
            reset_n_next = 1'b0;
            cnt_next = RPH_LOAD;
          end else begin
            ce_n_next = I_USER_CE_N;
            oe_n_next = I_USER_OE_N;
          end
        end
        default: begin
          state_next = frs_pkg::FRS_PWR_OFF;
          reset_n_next = 1'b0;
          cnt_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= frs_pkg::FRS_PWR_OFF;
      cnt_reg <= '0;
      reset_n_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      reset_n_reg <= reset_n_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign O_FLASH_RESET_N = reset_n_reg;
  assign O_FLASH_CE_N = ce_n_reg;
  assign O_FLASH_OE_N = oe_n_reg;
  assign O_ACCESS_READY = (state_reg == frs_pkg::FRS_ACTIVE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [`FRS_CNT_W-1:0] pwr_cnt_reg, low_cnt_reg, high_cnt_reg;
  logic [`FRS_CNT_W-1:0] pwr_cnt_next, low_cnt_next, high_cnt_next;

  // Low count covers every cycle the pin was low
  always_comb begin
    pwr_cnt_next = pwr_cnt_reg;
    low_cnt_next = low_cnt_reg;
    high_cnt_next = high_cnt_reg;
    if (!I_PWR_GOOD) begin
      pwr_cnt_next = '0;
    end else if (pwr_cnt_reg != CNT_MAX) begin
      pwr_cnt_next = pwr_cnt_reg + CNT_ONE;
    end
    if (!reset_n_reg) begin
      high_cnt_next = '0;
      if (low_cnt_reg != CNT_MAX) begin
        low_cnt_next = low_cnt_reg + CNT_ONE;
      end
    end else begin
      if (!reset_n_next) begin
        low_cnt_next = '0;
      end
      if (high_cnt_reg != CNT_MAX) begin
        high_cnt_next = high_cnt_reg + CNT_ONE;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pwr_cnt_reg <= '0;
      low_cnt_reg <= '0;
      high_cnt_reg <= '0;
    end else begin
      pwr_cnt_reg <= pwr_cnt_next;
      low_cnt_reg <= low_cnt_next;
      high_cnt_reg <= high_cnt_next;
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  a_select_after_setup: assert property (
    !O_FLASH_CE_N |-> pwr_cnt_reg >= SETUP_LOAD) else $error("select before supply setup");
  a_select_after_por: assert property (
    !O_FLASH_CE_N |-> pwr_cnt_reg >= SETUP_LOAD + RPH_LOAD) else $error("select in power-up");
  a_reset_low_width: assert property (
    $rose(O_FLASH_RESET_N) |-> low_cnt_reg >= RPH_LOAD) else $error("reset low too short");
  a_pulse_sum_ok: assert property (
    $fell(O_FLASH_CE_N) |-> ({1'b0, low_cnt_reg} + {1'b0, high_cnt_reg} >= {1'b0, RPH_LOAD})
    && (low_cnt_reg >= RP_LOAD))
    else $error("reset pulse sum short");
  a_recovery_high: assert property (
    !O_FLASH_CE_N |-> high_cnt_reg >= RH_LOAD) else $error("recovery too short");
  a_recovery_count: assert property (
    $rose(O_FLASH_RESET_N) |-> O_FLASH_CE_N [*3]) else $error("select inside 50 ns");
  a_por_reset_held: assert property (
    state_reg == frs_pkg::FRS_SUPPLY_SETUP |-> !O_FLASH_RESET_N)
    else $error("reset released in setup");
  a_rph_from_setup: assert property (
    (state_reg == frs_pkg::FRS_SUPPLY_SETUP) ##1 (state_reg == frs_pkg::FRS_RESET_LOW)
    |-> !O_FLASH_RESET_N [*8]) else $error("warm interval not from setup end");
  a_gate_closed: assert property (
    state_reg != frs_pkg::FRS_ACTIVE |=> O_FLASH_CE_N && O_FLASH_OE_N)
    else $error("strobe while blocked");
  a_ready_needs_idle: assert property (
    $rose(O_ACCESS_READY) |-> O_FLASH_RESET_N && $past(I_READY_BUSY_OUT_N))
    else $error("access opened while busy");
  a_warm_enters_low: assert property (
    O_ACCESS_READY && I_WARM_RESET_REQ && I_PWR_GOOD
    |=> !O_FLASH_RESET_N && (state_reg == frs_pkg::FRS_RESET_LOW))
    else $error("warm request not taken");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_first_access: cover property ($fell(O_FLASH_CE_N));
  c_power_loss: cover property (state_reg == frs_pkg::FRS_RESET_LOW && !I_PWR_GOOD);
  c_warm_reset: cover property (O_ACCESS_READY && I_WARM_RESET_REQ ##1 !O_FLASH_RESET_N);
  c_busy_wait: cover property (state_reg == frs_pkg::FRS_WAIT_READY && !I_READY_BUSY_OUT_N);

endmodule
`default_nettype wire

/* rtl/frs_map.svh */
// Constants for the flash reset sequencing host
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

`define FRS_CLK_MHZ 50
`define FRS_CNT_W 16
`define FRS_SETUP_TIME_US 300
`define FRS_SETUP_CYC (`FRS_SETUP_TIME_US * `FRS_CLK_MHZ)
`define FRS_RPH_TIME_US 35
`define FRS_RPH_CYC (`FRS_RPH_TIME_US * `FRS_CLK_MHZ)
`define FRS_RP_TIME_NS 200
`define FRS_RP_CYC ((`FRS_RP_TIME_NS * `FRS_CLK_MHZ + 999) / 1000)
`define FRS_RH_TIME_NS 50
`define FRS_RH_CYC ((`FRS_RH_TIME_NS * `FRS_CLK_MHZ + 999) / 1000)

`endif

/* rtl/frs_pkg.sv */
// Types for the flash reset sequencing host
`default_nettype none
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_PWR_OFF,
    FRS_SUPPLY_SETUP,
    FRS_RESET_LOW,
    FRS_RESET_HIGH,
    FRS_WAIT_READY,
    FRS_ACTIVE
  } frs_state_type;
endpackage
`default_nettype wire

/* verification/frs_flash_model.sv */
// Behavioural flash device answering reset with ready/busy
`timescale 1ns/100ps
`default_nettype none
module frs_flash_model #(
  parameter int COLD_CYC = 30,
  parameter int WARM_CYC = 100
) (
  input wire logic i_clk, // System clock
  input wire logic i_pwr_good, // Supplies up
  input wire logic i_reset_n, // Reset pin, active low
  input wire logic i_ce_n, // Chip enable, ignored here
  input wire logic i_slow, // Stretch busy time
  output wire logic o_ready_busy_out_n // Open drain, low is busy
);
  // ----------------------------------------
  // Reset algorithms
  // ----------------------------------------
  int busy_cnt = 0;
  int extra;
  logic cold_done = 1'b0;
  logic pg_q = 1'b0;
  logic rst_q = 1'b1;
  assign extra = i_slow ? 2000 : 0;
  assign o_ready_busy_out_n = (busy_cnt > 0) ? 1'b0 : 1'bz;
  always @(posedge i_clk) begin
    pg_q <= i_pwr_good;
    rst_q <= i_reset_n;
    if (!i_pwr_good) begin
      busy_cnt <= 0;
      cold_done <= 1'b0;
    end
    else if (!pg_q) busy_cnt <= COLD_CYC + extra;
    else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      cold_done <= cold_done | (busy_cnt == 1);
    end
    // warm or cold on reset fall
    else if (rst_q && !i_reset_n) busy_cnt <= (cold_done ? WARM_CYC : COLD_CYC) + extra;
  end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the flash reset sequencing host
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int SETUP = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pg = 1'b0;
  logic req = 1'b0;
  logic ce = 1'b1;
  logic oe = 1'b1;
  logic slow = 1'b0;
  tri1 rb_n;
  logic f_rst_n, f_ce_n, f_oe_n, ar, e_ce, e_oe, p_ce, p_rst, p_ar, p_rb;
  int miscompares = 0;
  int compares = 0;
  int need = 0;
  int rl_cnt = 0;
  int rh_cnt = 0;
  always #10 clk = ~clk;
  frs_host #(.SETUP_CYC(SETUP)) DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_PWR_GOOD(pg),
    .I_WARM_RESET_REQ(req), .I_USER_CE_N(ce), .I_USER_OE_N(oe), .I_READY_BUSY_OUT_N(rb_n),
    .O_FLASH_RESET_N(f_rst_n), .O_FLASH_CE_N(f_ce_n), .O_FLASH_OE_N(f_oe_n),
    .O_ACCESS_READY(ar));
  frs_flash_model FLASH (.i_clk(clk), .i_pwr_good(pg), .i_reset_n(f_rst_n), .i_ce_n(f_ce_n),
    .i_slow(slow), .o_ready_busy_out_n(rb_n));
  task automatic cmp_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_min(input int got, input int lim);
    compares++;
    if (got < lim) begin
      miscompares++;
      $display("Error at %0t: got %0h below %0h", $time, got, lim);
    end
  endtask
  task automatic give_verdict;
    $display("Compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (ar !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 9000) begin
        miscompares++;
        give_verdict();
      end
    end
  endtask
  task automatic warm(input logic s);
    @(posedge clk);
    slow <= s;
    req <= 1'b1;
    need = 1750;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    cmp_pin(ar, 1'b0);
    wait_ready();
  endtask
  // ----------------------------------------
  // Random strobes and per-cycle model
  // ----------------------------------------
  always @(posedge clk) begin
    ce <= 1'($urandom);
    oe <= 1'($urandom);
  end
  always begin
    @(posedge clk);
    e_ce = (ar && !req && pg && rst_n) ? ce : 1'b1;
    e_oe = (ar && !req && pg && rst_n) ? oe : 1'b1;
    p_ce = f_ce_n;
    p_rst = f_rst_n;
    p_ar = ar;
    p_rb = rb_n;
    @(negedge clk);
    if (!rst_n) begin
      e_ce = 1'b1;
      e_oe = 1'b1;
    end
    cmp_pin(f_ce_n, e_ce);
    cmp_pin(f_oe_n, e_oe);
    if (ar && !p_ar) cmp_pin(p_rb, 1'b1);
    if (!f_ce_n && p_ce) cmp_min(rh_cnt, 3);
    if (f_rst_n && !p_rst && pg) cmp_min(rl_cnt, need);
    rl_cnt = (!f_rst_n && pg) ? rl_cnt + 1 : 0;
    rh_cnt = f_rst_n ? rh_cnt + 1 : 0;
  end
  initial begin
    void'($urandom(32'h3E4C9918));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    pg <= 1'b1;
    need = SETUP + 1750;
    wait_ready();
    repeat (50) @(posedge clk);
    for (int i = 0; i < 4; i++) warm(i[0]);
    @(posedge clk);
    pg <= 1'b0;
    repeat (3) @(posedge clk);
    pg <= 1'b1;
    need = SETUP + 1750;
    repeat (900) @(posedge clk);
    pg <= 1'b0;
    repeat (3) @(posedge clk);
    pg <= 1'b1;
    wait_ready();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_ready();
    warm(1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
